/* seq_status_params.svh */
// constants for the target sequence status block: register offsets, codes, layout
// assumes inclusion by the package and by both design files
`ifndef SEQ_STATUS_PARAMS_SVH
`define SEQ_STATUS_PARAMS_SVH

// ==================================================
// register map (word addresses, one 32-bit word each)
`define OFF_INTERRUPT_CAUSE 8'h05
`define OFF_SEQUENCE_STEP   8'h06
`define OFF_SEQ_COMMAND     8'h00
`define OFF_FIFO_COUNT      8'h07
`define OFF_FIFO_DATA       8'h02
`define ADDR_W              8

// ==================================================
// step codes
`define STEP_0 3'h0
`define STEP_1 3'h1
`define STEP_2 3'h2

// ==================================================
// interrupt status codes
`define CAUSE_DONE  8'h08
`define CAUSE_ATN   8'h18
`define CAUSE_FREE  8'h28
`define CAUSE_NONE  8'h00

// ==================================================
// command codes written by software
`define CMD_RECEIVE   2'h0
`define CMD_DISCON    2'h1
`define CMD_TERMINATE 2'h2
`define CMD_COMPLETE  2'h3

// ==================================================
// fifo and command block layout
`define FIFO_DEPTH  16
`define FIFO_AW     4
`define FIFO_CNT_W  5
`define CDB_LEN     4'h6
`define READ_ZERO   32'h0000_0000
`define CMD_GO_BIT  8

`endif

/* seq_status_pkg.sv */
// types for the target sequence status block
// assumes seq_status_params.svh is on the include path
`default_nettype none
`include "seq_status_params.svh"
package seq_status_pkg;
	typedef struct packed {
		logic [2:0] step;
		logic [7:0] cause;
	} report_t;

	typedef struct packed {
		logic       req;
		logic       ack;
		logic [7:0] data;
		logic       parity;
		logic       atn;
	} scsi_in_t;

	typedef enum logic [1:0] {
		seq_receive,
		seq_discon,
		seq_terminate,
		seq_complete
	} seq_kind_t;
endpackage
`default_nettype wire

/* seq_fifo.sv */
// byte fifo that keeps received command bytes for the host
// assumes one clock; writer and reader on the same clock
`default_nettype none
`include "seq_status_params.svh"
module seq_fifo (
	input  wire logic                     clk_i,
	input  wire logic                     sys_rst_i,
	input  wire logic                     wr_i,
	input  wire logic [7:0]               wdata_i,
	input  wire logic                     rd_i,
	output logic      [7:0]               rdata_o,
	output logic      [`FIFO_CNT_W-1:0]   count_o
);
	logic [7:0]               mem_reg [`FIFO_DEPTH];
	logic [`FIFO_AW-1:0]      wptr_reg;
	logic [`FIFO_AW-1:0]      rptr_reg;
	logic [`FIFO_CNT_W-1:0]   cnt_reg;
	wire                      do_wr = wr_i && (cnt_reg != `FIFO_CNT_W'(`FIFO_DEPTH));
	wire                      do_rd = rd_i && (cnt_reg != '0);

	always_ff @(posedge clk_i) begin
		if (do_wr)
			mem_reg[wptr_reg] <= wdata_i;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			cnt_reg  <= '0;
		end else begin
			wptr_reg <= wptr_reg + `FIFO_AW'(do_wr);
			rptr_reg <= rptr_reg + `FIFO_AW'(do_rd);
			cnt_reg  <= cnt_reg + `FIFO_CNT_W'(do_wr) - `FIFO_CNT_W'(do_rd);
		end
	end

	assign rdata_o = mem_reg[rptr_reg];
	assign count_o = cnt_reg;
endmodule
`default_nettype wire

/* seq_status.sv */
// target sequence engine reduced to its completion and halt reporting
// assumes an avalon-mm master on clk_i and scsi pins from outside the clock domain
`default_nettype none
`include "seq_status_params.svh"
module seq_status (
	input  wire logic                      clk_i,
	input  wire logic                      sys_rst_i,
	input  wire logic [`ADDR_W-1:0]        avs_address_i,
	input  wire logic                      avs_read_i,
	input  wire logic                      avs_write_i,
	input  wire logic [31:0]               avs_writedata_i,
	output logic      [31:0]               avs_readdata_o,
	output logic                           avs_waitrequest_o,
	input  wire seq_status_pkg::scsi_in_t  scsi_i,
	output logic                           scsi_req_o,
	output logic      [7:0]                scsi_data_o,
	output logic                           scsi_data_oe_o,
	output logic                           scsi_bsy_o,
	output logic                           seq_irq_o
);
	// ==================================================
	// pin synchronisers
	seq_status_pkg::scsi_in_t pin_meta_reg;
	seq_status_pkg::scsi_in_t pin_reg;
	logic                     ack_prev_reg;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pin_meta_reg <= '0;
			pin_reg      <= '0;
			ack_prev_reg <= 1'b0;
		end else begin
			pin_meta_reg <= scsi_i;
			pin_reg      <= pin_meta_reg;
			ack_prev_reg <= pin_reg.ack;
		end
	end

	wire ack_rise = pin_reg.ack && !ack_prev_reg;
	wire atn      = pin_reg.atn;
	wire par_bad  = ~^{pin_reg.data, pin_reg.parity};

	// ==================================================
	// register bus decode
	typedef enum logic [2:0] {
		st_idle,
		st_cmd_req,
		st_cmd_ack,
		st_stat,
		st_msg,
		st_release
	} state_t;

	state_t                   state_reg;
	state_t                   state_next;
	seq_status_pkg::seq_kind_t kind_reg;
	logic                     pend_reg;
	logic  [2:0]              step_reg;
	logic  [7:0]              cause_reg;
	logic  [3:0]              bytes_reg;
	logic  [31:0]             rdata_reg;
	logic                     wait_reg;
	logic  [`FIFO_CNT_W-1:0]  fifo_count;
	logic  [7:0]              fifo_rdata;

	function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	// one wait cycle on every access so read data is registered
	wire bus_req   = (avs_read_i || avs_write_i) && wait_reg;
	wire rd_cause  = bus_req && avs_read_i && hit(avs_address_i, `OFF_INTERRUPT_CAUSE);
	wire rd_fifo   = bus_req && avs_read_i && hit(avs_address_i, `OFF_FIFO_DATA);
	wire wr_cmd    = bus_req && avs_write_i && hit(avs_address_i, `OFF_SEQ_COMMAND)
	                 && avs_writedata_i[`CMD_GO_BIT];
	wire start     = wr_cmd && (state_reg == st_idle);
	wire [1:0] cmd = avs_writedata_i[1:0];

	wire [31:0] rd_mux =
		hit(avs_address_i, `OFF_INTERRUPT_CAUSE) ? {24'h0, cause_reg} :
		hit(avs_address_i, `OFF_SEQUENCE_STEP)   ? {29'h0, step_reg} :
		hit(avs_address_i, `OFF_FIFO_COUNT)      ? {27'h0, fifo_count} :
		hit(avs_address_i, `OFF_FIFO_DATA)       ? {24'h0, fifo_rdata} :
		hit(avs_address_i, `OFF_SEQ_COMMAND)     ? {29'h0, (state_reg != st_idle), kind_reg} :
		`READ_ZERO;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wait_reg  <= 1'b1;
			rdata_reg <= '0;
		end else begin
			wait_reg  <= !bus_req;
			if (bus_req)
				rdata_reg <= rd_mux;
		end
	end

	// ==================================================
	// sequence engine
	wire in_cmd   = (state_reg == st_cmd_ack) && ack_rise;
	wire cdb_done = in_cmd && !par_bad && (bytes_reg == `CDB_LEN - 4'h1);
	wire par_halt = in_cmd && par_bad;
	wire stat_out = (state_reg == st_stat) && ack_rise;
	wire msg_out  = (state_reg == st_msg) && ack_rise;
	wire rel_done = (state_reg == st_release);

	// report capture: which step and cause the current event produces
	logic                     fin;
	seq_status_pkg::report_t  rep;

	always_comb begin
		fin = 1'b0;
		rep = '{step: `STEP_0, cause: `CAUSE_NONE};
		if (cdb_done) begin
			fin = 1'b1;
			rep = atn ? '{step: `STEP_2, cause: `CAUSE_ATN}
			          : '{step: `STEP_2, cause: `CAUSE_DONE};
		end else if (par_halt) begin
			fin = 1'b1;
			rep = atn ? '{step: `STEP_1, cause: `CAUSE_ATN}
			          : '{step: `STEP_1, cause: `CAUSE_DONE};
		end else if (stat_out && atn) begin
			fin = 1'b1;
			rep = '{step: `STEP_0, cause: `CAUSE_ATN};
		end else if (msg_out && atn) begin
			fin = 1'b1;
			rep = '{step: `STEP_1, cause: `CAUSE_ATN};
		end else if (msg_out && kind_reg == seq_status_pkg::seq_complete) begin
			fin = 1'b1;
			rep = '{step: `STEP_2, cause: `CAUSE_DONE};
		end else if (rel_done) begin
			fin = 1'b1;
			rep = (kind_reg == seq_status_pkg::seq_terminate)
			      ? '{step: `STEP_2, cause: `CAUSE_FREE}
			      : '{step: `STEP_0, cause: `CAUSE_FREE};
		end
	end

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			st_idle: begin
				if (start) begin
					unique case (cmd)
						`CMD_RECEIVE:   state_next = st_cmd_req;
						`CMD_DISCON:    state_next = st_release;
						`CMD_TERMINATE: state_next = st_stat;
						`CMD_COMPLETE:  state_next = st_stat;
					endcase
				end
			end
			st_cmd_req: state_next = st_cmd_ack;
			st_cmd_ack: begin
				if (fin)
					state_next = st_idle;
				else if (ack_rise)
					state_next = st_cmd_req;
			end
			st_stat: begin
				if (fin)
					state_next = st_idle;
				else if (stat_out)
					state_next = st_msg;
			end
			st_msg: begin
				if (fin)
					state_next = st_idle;
				else if (msg_out)
					state_next = st_release;
			end
			st_release: state_next = st_idle;
		endcase
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg <= st_idle;
			kind_reg  <= seq_status_pkg::seq_receive;
			bytes_reg <= '0;
		end else begin
			state_reg <= state_next;
			if (start) begin
				kind_reg  <= seq_status_pkg::seq_kind_t'(cmd);
				bytes_reg <= '0;
			end else if (in_cmd)
				bytes_reg <= bytes_reg + 4'h1;
		end
	end

	// ==================================================
	// status capture; a new report wins over the clearing read
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			step_reg  <= `STEP_0;
			cause_reg <= `CAUSE_NONE;
			pend_reg  <= 1'b0;
		end else if (fin) begin
			step_reg  <= rep.step;
			cause_reg <= rep.cause;
			pend_reg  <= 1'b1;
		end else if (rd_cause)
			pend_reg  <= 1'b0;
	end

	// ==================================================
	// scsi drive
	logic req_reg;
	logic oe_reg;
	logic bsy_reg;
	logic [7:0] dout_reg;
	wire  drive_in = (state_next == st_stat) || (state_next == st_msg);

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			req_reg  <= 1'b0;
			oe_reg   <= 1'b0;
			bsy_reg  <= 1'b0;
			dout_reg <= '0;
		end else begin
			req_reg  <= (state_next == st_cmd_req) || (drive_in && !ack_rise);
			oe_reg   <= drive_in;
			dout_reg <= (state_next == st_msg) ? 8'h00 : 8'h02;
			bsy_reg  <= (state_next != st_idle) && (state_next != st_release);
		end
	end

	// ==================================================
	// fifo keeps command bytes across a halt
	seq_fifo u_fifo (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.wr_i      (in_cmd && !par_bad),
		.wdata_i   (pin_reg.data),
		.rd_i      (rd_fifo),
		.rdata_o   (fifo_rdata),
		.count_o   (fifo_count)
	);

	assign avs_readdata_o    = rdata_reg;
	assign avs_waitrequest_o = wait_reg;
	assign scsi_req_o        = req_reg;
	assign scsi_data_o       = dout_reg;
	assign scsi_data_oe_o    = oe_reg;
	assign scsi_bsy_o        = bsy_reg;
	assign seq_irq_o         = pend_reg;

	// ==================================================
	// checks: report codes
	a_cdb_atn: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		cdb_done && atn |=> step_reg == `STEP_2 && cause_reg == `CAUSE_ATN)
		else $error("cdb with atn wrong code");
	a_cdb_plain: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		cdb_done && !atn |=> step_reg == `STEP_2 && cause_reg == `CAUSE_DONE)
		else $error("cdb without atn wrong code");
	a_par_atn: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		par_halt && atn |=> step_reg == `STEP_1 && cause_reg == `CAUSE_ATN)
		else $error("parity with atn wrong code");
	a_par_plain: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		par_halt && !atn |=> step_reg == `STEP_1 && cause_reg == `CAUSE_DONE)
		else $error("parity wrong code");
	a_par_stop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		par_halt |=> state_reg == st_idle && !req_reg)
		else $error("parity halt kept handshaking");
	a_stat_atn: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		stat_out && atn |=> step_reg == `STEP_0 && state_reg == st_idle)
		else $error("status halt wrong");
	a_cmp_stat: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		stat_out && atn && kind_reg == seq_status_pkg::seq_complete
		|=> step_reg == `STEP_0 && cause_reg == `CAUSE_ATN)
		else $error("complete status halt wrong");
	a_stat_stop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		stat_out && atn |=> !oe_reg && !req_reg)
		else $error("message byte offered after halt");
	a_msg_atn: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		msg_out && atn |=> step_reg == `STEP_1 && cause_reg == `CAUSE_ATN)
		else $error("message halt wrong");
	a_cmp_msg: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		msg_out && atn && kind_reg == seq_status_pkg::seq_complete
		|=> step_reg == `STEP_1 && cause_reg == `CAUSE_ATN)
		else $error("complete message halt wrong");
	a_msg_stop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		msg_out && atn |=> state_reg == st_idle && !oe_reg)
		else $error("message halt kept driving");
	a_cmp_done: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		msg_out && !atn && kind_reg == seq_status_pkg::seq_complete
		|=> step_reg == `STEP_2 && cause_reg == `CAUSE_DONE)
		else $error("complete end wrong code");
	a_free_bus: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		rel_done |=> !bsy_reg && cause_reg == `CAUSE_FREE)
		else $error("bus not freed");
	a_term_free: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		rel_done && kind_reg == seq_status_pkg::seq_terminate
		|=> step_reg == `STEP_2 && cause_reg == `CAUSE_FREE && !bsy_reg)
		else $error("terminate end wrong code");

	// ==================================================
	// checks: report hold, bus and fifo
	a_report_pair: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$rose(pend_reg) |-> (cause_reg != `CAUSE_NONE))
		else $error("report raised without cause");
	a_step_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!fin |=> $stable(step_reg) && $stable(cause_reg))
		else $error("report changed without event");
	a_pend_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		fin |=> pend_reg)
		else $error("report without interrupt");
	a_irq_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		rd_cause && !fin |=> !pend_reg)
		else $error("interrupt not cleared by read");
	a_irq_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		pend_reg && !rd_cause |=> pend_reg)
		else $error("interrupt dropped before read");
	a_oe_free: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!bsy_reg |-> !oe_reg)
		else $error("data driven while bus free");
	a_fifo_keep: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		par_halt && !rd_fifo |=> $stable(fifo_count))
		else $error("fifo lost bytes on halt");

	c_receive: cover property (@(posedge clk_i) disable iff (sys_rst_i) cdb_done);
	c_par: cover property (@(posedge clk_i) disable iff (sys_rst_i) par_halt);
	c_term: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		rel_done && kind_reg == seq_status_pkg::seq_terminate);
	c_halt_atn: cover property (@(posedge clk_i) disable iff (sys_rst_i) stat_out && atn);
	c_complete: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		msg_out && !atn && kind_reg == seq_status_pkg::seq_complete);
endmodule
`default_nettype wire

/* scsi_initiator_model.sv */
// initiator side of the scsi link: one ack handshake for every req
// assumes req_i comes straight from the target's registered req output
`default_nettype none
module scsi_initiator_model (
	input  wire logic                     clk_i,
	input  wire logic                     sys_rst_i,
	input  wire logic                     req_i,
	input  wire logic                     clr_i,
	input  wire logic [2:0]               atn_from_i,
	input  wire logic [2:0]               bad_at_i,
	output var  seq_status_pkg::scsi_in_t scsi_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic      [2:0] cnt_reg;
	wire logic [7:0] pat = 8'h31 + {5'h00, cnt_reg};
	// ==================================================
	// handshake
	// bytes carry a running pattern so the host side can check what it recovers
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			scsi_o  <= '0;
			cnt_reg <= 3'h0;
		end else if (clr_i) begin
			cnt_reg <= 3'h0;
		end else if (req_i && !scsi_o.ack) begin
			scsi_o.ack    <= 1'b1;
			scsi_o.data   <= pat;
			scsi_o.parity <= (~^pat) ^ (cnt_reg == bad_at_i);
			scsi_o.atn    <= (cnt_reg >= atn_from_i);
		end else if (!req_i && scsi_o.ack) begin
			scsi_o.ack  <= 1'b0;
			// lines released: show no stale byte
			scsi_o.data <= ~scsi_o.data;
			cnt_reg     <= cnt_reg + 3'h1;
		end
	end
endmodule
`default_nettype wire

/* scsi_target_sequence_status_bench.sv */
// self-checking bench: sequence status reports read over avalon-mm
// assumes seq_status_params.svh on the include path, initiator model beside it
`default_nettype none
module scsi_target_sequence_status_bench;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic [1:0] kind;
		logic [2:0] atn;
		logic [2:0] bad;
		logic [2:0] step;
		logic [7:0] cause;
		logic [4:0] n;
		logic       free;
	} row_t;
	// ==================================================
	// cases: 7 in atn or bad means never
	row_t rows [11] = '{
		'{2'h0, 3'h7, 3'h7, 3'h2, 8'h08, 5'h06, 1'b0},
		'{2'h0, 3'h0, 3'h7, 3'h2, 8'h18, 5'h06, 1'b0},
		'{2'h0, 3'h0, 3'h3, 3'h1, 8'h18, 5'h03, 1'b0},
		'{2'h0, 3'h7, 3'h3, 3'h1, 8'h08, 5'h03, 1'b0},
		'{2'h1, 3'h7, 3'h7, 3'h0, 8'h28, 5'h00, 1'b1},
		'{2'h2, 3'h7, 3'h7, 3'h2, 8'h28, 5'h00, 1'b1},
		'{2'h2, 3'h1, 3'h7, 3'h1, 8'h18, 5'h00, 1'b0},
		'{2'h2, 3'h0, 3'h7, 3'h0, 8'h18, 5'h00, 1'b0},
		'{2'h3, 3'h1, 3'h7, 3'h1, 8'h18, 5'h00, 1'b0},
		'{2'h3, 3'h0, 3'h7, 3'h0, 8'h18, 5'h00, 1'b0},
		'{2'h3, 3'h7, 3'h7, 3'h2, 8'h08, 5'h00, 1'b0}};
	logic                     clk_i = 1'b0;
	logic                     sys_rst_i = 1'b1;
	logic [7:0]               avs_address_i = 8'h00;
	logic                     avs_read_i = 1'b0;
	logic                     avs_write_i = 1'b0;
	logic [31:0]              avs_writedata_i = 32'h0000_0000;
	logic [31:0]              avs_readdata_o;
	logic                     avs_waitrequest_o;
	seq_status_pkg::scsi_in_t scsi_i;
	logic                     scsi_req_o;
	logic [7:0]               scsi_data_o;
	logic                     scsi_data_oe_o;
	logic                     scsi_bsy_o;
	logic                     seq_irq_o;
	logic                     clr = 1'b0;
	logic [2:0]               atn_from = 3'h7;
	logic [2:0]               bad_at = 3'h7;
	int                       err_count = 0;
	int                       num_checks = 0;
	int                       cyc = 0;
	logic [31:0]              d;
	initial forever #12.5 clk_i = ~clk_i;
	seq_status i_seq_status (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .scsi_i(scsi_i), .scsi_req_o(scsi_req_o),
		.scsi_data_o(scsi_data_o), .scsi_data_oe_o(scsi_data_oe_o),
		.scsi_bsy_o(scsi_bsy_o), .seq_irq_o(seq_irq_o));
	scsi_initiator_model i_scsi_initiator_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.req_i(scsi_req_o), .clr_i(clr), .atn_from_i(atn_from), .bad_at_i(bad_at),
		.scsi_o(scsi_i));
	// ==================================================
	// tasks
	task automatic report_and_stop();
		if (err_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
		end
	endtask
	// request held until waitrequest is sampled low at a rising edge; data taken there
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] q);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_read_i    <= 1'b1;
		@(posedge clk_i);
		while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
	endtask
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		avs_address_i   <= a;
		avs_writedata_i <= v;
		avs_write_i     <= 1'b1;
		@(posedge clk_i);
		while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
		avs_write_i <= 1'b0;
	endtask
	task automatic start(input row_t r);
		@(posedge clk_i);
		clr      <= 1'b1;
		atn_from <= r.atn;
		bad_at   <= r.bad;
		@(posedge clk_i);
		clr <= 1'b0;
		bus_wr(8'h00, {23'h0, 1'b1, 6'h00, r.kind});
	endtask
	task automatic finish(input row_t r);
		logic [31:0] q;
		for (int k = 0; k < 3000 && seq_irq_o !== 1'b1; k++) @(negedge clk_i);
		bus_rd(8'h06, q);
		chk(q, {29'h0, r.step});
		@(negedge clk_i);
		chk({31'h0, seq_irq_o}, 32'h1);
		bus_rd(8'h05, q);
		chk(q, {24'h0, r.cause});
		@(negedge clk_i);
		chk({31'h0, seq_irq_o}, 32'h0);
		if (r.free) begin
			chk({31'h0, scsi_bsy_o}, 32'h0);
			chk({31'h0, scsi_data_oe_o}, 32'h0);
		end
		bus_rd(8'h07, q);
		chk(q, {27'h0, r.n});
		for (int j = 0; j < r.n; j++) begin
			bus_rd(8'h02, q);
			chk(q, {24'h0, 8'h31 + 8'(j)});
		end
	endtask
	// ==================================================
	// run
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			report_and_stop();
		end
	end
	initial begin
		repeat (4) @(negedge clk_i);
		chk({29'h0, avs_waitrequest_o, seq_irq_o, scsi_bsy_o}, 32'h4);
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		bus_rd(8'h05, d);
		chk(d, 32'h0000_0000);
		// unmapped: write ignored, read gives zero
		bus_wr(8'h10, 32'h0000_00ff);
		bus_rd(8'h10, d);
		chk(d, 32'h0000_0000);
		foreach (rows[i]) begin
			start(rows[i]);
			finish(rows[i]);
		end
		// second command while receive runs must not disturb its report
		start(rows[0]);
		bus_wr(8'h00, 32'h0000_0102);
		finish(rows[0]);
		// reset in mid-sequence, before its report, clears the interrupt and the cause
		start(rows[5]);
		repeat (6) @(posedge clk_i);
		sys_rst_i <= 1'b1;
		@(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(negedge clk_i);
		chk({31'h0, seq_irq_o}, 32'h0);
		bus_rd(8'h05, d);
		chk(d, 32'h0000_0000);
		report_and_stop();
	end
endmodule
`default_nettype wire
